/* hdl/cnm_params.svh */
// Constants of the node messaging block.
// Assumes inclusion by bare name.
`ifndef CNM_PARAMS_SVH
`define CNM_PARAMS_SVH

// Fixed identifiers and function codes (11-bit).
`define CNM_ID_NMT    11'h000
`define CNM_ID_SYNC   11'h080
`define CNM_ID_TIME   11'h100
`define CNM_FC_EMCY   11'h080
`define CNM_FC_TPDO1  11'h180
`define CNM_FC_RPDO1  11'h200
`define CNM_FC_ERRCTL 11'h700

// Node number limits.
`define CNM_NODE_ALL  8'h00
`define CNM_NODE_RST  7'h01

// Network management command specifiers.
`define CNM_CS_START  8'h01
`define CNM_CS_STOP   8'h02
`define CNM_CS_PREOP  8'h80
`define CNM_CS_RNODE  8'h81
`define CNM_CS_RCOMM  8'h82
`define CNM_NMT_DLC   4'h2

// Node state codes.
`define CNM_ST_BOOT   7'h00
`define CNM_ST_STOP   7'h04
`define CNM_ST_OP     7'h05
`define CNM_ST_PREOP  7'h7f

// Transmission types.
`define CNM_TT_ACYC   8'h00
`define CNM_TT_CYCMAX 8'hf0
`define CNM_TT_ASYNC  8'hfe

// Frame lengths.
`define CNM_DLC_BYTE  4'h1
`define CNM_DLC_PDO   4'h8

// Register byte offsets and fields.
`define CNM_A_CTRL    8'h00
`define CNM_A_STAT    8'h04
`define CNM_A_HB      8'h08
`define CNM_A_GUARD   8'h0c
`define CNM_A_TCFG    8'h10
`define CNM_A_TDAT    8'h20
`define CNM_A_END     8'h40
`define CNM_F_NODE    6:0
`define CNM_F_MS      15:0
`define CNM_F_LIFE    23:16
`define CNM_F_TT      7:0
`define CNM_F_INH     31:16

// Reset values of configuration.
`define CNM_HB_RST    16'h0000
`define CNM_GT_RST    16'h0000
`define CNM_LF_RST    8'h00
`define CNM_TT_RST    8'hff
`define CNM_INH_RST   16'h0000

// Timing: one millisecond at a 25 ns clock.
`define CNM_MS_NS     1000000
`define CNM_CLK_NS    25

`endif

/* hdl/cnm_pkg.sv */
// Types shared by the node messaging block.
// Assumes the parameter header is on the include path.
`include "cnm_params.svh"

package cnm_pkg;
  typedef enum logic [1:0] {CNM_INIT, CNM_PREOP, CNM_OP, CNM_STOP} cnm_nmt_t;
  typedef enum logic [1:0] {CNM_TX_IDLE, CNM_TX_READ, CNM_TX_SEND} cnm_tx_t;
endpackage : cnm_pkg

/* hdl/cnm_pdo_mem.sv */
// Payload store of the four transmit process data objects, 64 bits each.
// Assumes one clock; written in 32-bit halves, read data registered.
`timescale 1ns/1ps
`default_nettype none

module cnm_pdo_mem (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // Write port.
  input  wire logic [1:0]  we,
  input  wire logic [1:0]  waddr,
  input  wire logic [31:0] wdata,
  // Read port.
  input  wire logic [1:0]  raddr,
  output var  logic [63:0] rdata_ff
);
  logic [63:0] mem [4];

  // Cleared on reset so a payload never written goes out as zeros, not unknowns.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      mem <= '{default: 64'h0};
    end else begin
      if (we[0]) begin
        mem[waddr][31:0] <= wdata;
      end
      if (we[1]) begin
        mem[waddr][63:32] <= wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_ff <= 64'h0;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end
endmodule : cnm_pdo_mem

`default_nettype wire

/* hdl/cnm_node.sv */
// Messaging layer of a fieldbus servo node: state machine, PDOs, guarding.
// Assumes a frame-level CAN controller on the same clock and an APB master.
//
// Notes on behaviour
// RULE1 - Node number 1 to 127; zero means all.
// RULE2 - Identifier is class code plus node number.
// RULE3 - Fixed management, sync, time and error identifiers.
// RULE4 - Transmit PDOs on 180, 280, 380, 480 plus node.
// RULE5 - Receive PDOs on 200, 300, 400, 500 plus node.
// RULE6 - Types 0 to 240 send only on sync.
// RULE7 - Master sends sync at most 1 kHz.
// RULE8 - Acyclic: armed by remote or event, sent on sync.
// RULE9 - Cyclic type n: send every n syncs.
// RULE10 - Types 254 and 255 send on change.
// RULE11 - Inhibit time in ms spaces transmissions.
// RULE12 - Heartbeat sends state byte on 700 plus node.
// RULE13 - Master alarms on missing heartbeat.
// RULE14 - Master guards with remote frame on 700.
// RULE15 - Guard reply toggles bit 7, first zero.
// RULE16 - Guard reply bits 0 to 6 hold state.
// RULE17 - Alarm after guard time times life factor.
// RULE18 - After init enter pre-operational, send boot-up.
// RULE19 - Command frame: specifier then node, zero all.
// RULE20 - Specifiers 01, 02, 80, 82 change state.
// RULE21 - Commands are obeyed and never answered.
// RULE22 - PDOs exchanged only while operational.
// RULE23 - Specifier 81 resets node; foreign node ignored.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "cnm_params.svh"

module cnm_node
  import cnm_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `CNM_MS_NS / `CNM_CLK_NS
) (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rstn,
  // APB slave.
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Received frames.
  input  wire logic        rx_valid,
  input  wire logic [10:0] rx_id,
  input  wire logic        rx_rtr,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [63:0] rx_data,
  // Frames to send.
  output var  logic        tx_valid,
  output var  logic [10:0] tx_id,
  output var  logic [3:0]  tx_dlc,
  output var  logic [63:0] tx_data,
  input  wire logic        tx_ready,
  // Application side.
  input  wire logic [3:0]  tpdo_evt,
  output var  logic        rpdo_valid,
  output var  logic [1:0]  rpdo_idx,
  output var  logic [3:0]  rpdo_dlc,
  output var  logic [63:0] rpdo_data,
  output var  logic        guard_alarm,
  output var  logic [6:0]  nmt_state
);
  function automatic logic [10:0] cob(input logic [10:0] fc, input logic [6:0] node);
    cob = fc + {4'h0, node}; // [RULE2]
  endfunction : cob

  function automatic logic [6:0] st_code(input cnm_nmt_t st);
    case (st)
      CNM_PREOP: st_code = `CNM_ST_PREOP;
      CNM_OP:    st_code = `CNM_ST_OP;
      CNM_STOP:  st_code = `CNM_ST_STOP;
      default:   st_code = `CNM_ST_BOOT;
    endcase
  endfunction : st_code

  logic [6:0]  node_ff;
  cnm_nmt_t    st_ff;
  logic [15:0] hb_ms_ff, gt_ms_ff;
  logic [7:0]  lf_ff;
  logic [7:0]  tt_ff [4];
  logic [15:0] inh_ff [4];
  logic [31:0] prdata_ff, rd_mux;
  logic        pready_ff, pslverr_ff, rd_err;
  logic [15:0] ms_cnt_ff, hb_cnt_ff;
  logic        tick;
  logic [23:0] life_cnt_ff;
  logic        guard_on_ff, alarm_ff, toggle_ff;
  logic        guard_pend_ff, hb_pend_ff, boot_pend_ff;
  logic [3:0]  pend_ff, armed_ff;
  logic [7:0]  cyc_ff [4];
  logic [16:0] inh_cnt_ff [4];
  cnm_tx_t     tx_st_ff;
  logic        tx_valid_ff;
  logic [10:0] tx_id_ff;
  logic [3:0]  tx_dlc_ff;
  logic [63:0] tx_data_ff, mem_rdata;
  logic [3:0]  lch_pdo;
  logic        lch_guard, lch_hb, lch_boot;
  logic [1:0]  lch_idx;
  logic        rpdo_valid_ff;
  logic [1:0]  rpdo_idx_ff;
  logic [3:0]  rpdo_dlc_ff;
  logic [63:0] rpdo_data_ff;

  // APB decode; the answer comes one cycle into the access phase.
  wire apb_acc  = psel & penable & ~pready_ff;
  wire apb_wr   = psel & penable & pready_ff & pwrite;
  wire a_tcfg   = paddr >= `CNM_A_TCFG && paddr < `CNM_A_TDAT;
  wire a_tdat   = paddr >= `CNM_A_TDAT && paddr < `CNM_A_END;
  wire [1:0] a_idx = a_tcfg ? paddr[3:2] : paddr[4:3];
  wire is_op    = st_ff == CNM_OP;

  // Command frames for another node are dropped before decoding.
  wire nmt_hit  = rx_valid & ~rx_rtr & rx_id == `CNM_ID_NMT & rx_dlc >= `CNM_NMT_DLC
                & (rx_data[15:8] == {1'b0, node_ff} | rx_data[15:8] == `CNM_NODE_ALL); // [RULE19] [RULE23]
  wire [7:0] cs = rx_data[7:0];
  wire node_rst = nmt_hit & cs == `CNM_CS_RNODE; // [RULE23]
  wire comm_rst = node_rst | (nmt_hit & cs == `CNM_CS_RCOMM); // [RULE20]
  wire sync_hit = rx_valid & ~rx_rtr & rx_id == `CNM_ID_SYNC & is_op; // [RULE3] [RULE6]
  wire guard_req = rx_valid & rx_rtr & rx_id == cob(`CNM_FC_ERRCTL, node_ff)
                 & st_ff != CNM_INIT; // [RULE14]
  wire [23:0] life_lim = gt_ms_ff * lf_ff;

  always_comb begin
    rd_err = (paddr[1:0] != 2'b00) | (paddr >= `CNM_A_END);
    rd_mux = 32'h0;
    if (a_tcfg) begin
      rd_mux = {inh_ff[a_idx], 8'h00, tt_ff[a_idx]};
    end else if (!a_tdat) begin
      case (paddr)
        `CNM_A_CTRL:  rd_mux = {25'h0, node_ff};
        `CNM_A_STAT:  rd_mux = {23'h0, toggle_ff, alarm_ff, st_code(st_ff)};
        `CNM_A_HB:    rd_mux = {16'h0, hb_ms_ff};
        `CNM_A_GUARD: rd_mux = {8'h00, lf_ff, gt_ms_ff};
        default:      rd_mux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= apb_acc;
      pslverr_ff <= apb_acc & rd_err;
      prdata_ff  <= (apb_acc && !pwrite && !rd_err) ? rd_mux : 32'h0;
    end
  end

  // Node number; zero is reserved for broadcast and never taken.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      node_ff <= `CNM_NODE_RST;
    end else if (apb_wr && paddr == `CNM_A_CTRL && pwdata[`CNM_F_NODE] != 7'h00) begin
      node_ff <= pwdata[`CNM_F_NODE]; // [RULE1]
    end
  end

  // Communication settings; a node reset restores them, unlike a comm reset.
  always_ff @(posedge core_clk) begin
    if (!rstn || node_rst) begin
      hb_ms_ff <= `CNM_HB_RST;
      gt_ms_ff <= `CNM_GT_RST;
      lf_ff    <= `CNM_LF_RST;
      for (int i = 0; i < 4; i++) begin
        tt_ff[i]  <= `CNM_TT_RST;
        inh_ff[i] <= `CNM_INH_RST;
      end
    end else if (apb_wr) begin
      if (paddr == `CNM_A_HB) begin
        hb_ms_ff <= pwdata[`CNM_F_MS];
      end
      if (paddr == `CNM_A_GUARD) begin
        gt_ms_ff <= pwdata[`CNM_F_MS];
        lf_ff    <= pwdata[`CNM_F_LIFE];
      end
      if (a_tcfg && paddr[1:0] == 2'b00) begin
        tt_ff[a_idx]  <= pwdata[`CNM_F_TT];
        inh_ff[a_idx] <= pwdata[`CNM_F_INH];
      end
    end
  end

  // Node state machine; commands change state and nothing is ever answered.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      st_ff <= CNM_INIT;
    end else begin
      case (st_ff)
        CNM_INIT: st_ff <= CNM_PREOP; // [RULE18]
        default: begin
          if (comm_rst) begin
            st_ff <= CNM_INIT; // [RULE20] [RULE21]
          end else if (nmt_hit && cs == `CNM_CS_START) begin
            st_ff <= CNM_OP;
          end else if (nmt_hit && cs == `CNM_CS_STOP) begin
            st_ff <= CNM_STOP;
          end else if (nmt_hit && cs == `CNM_CS_PREOP) begin
            st_ff <= CNM_PREOP;
          end
        end
      endcase
    end
  end

  // Millisecond enable for heartbeat, guarding and inhibit timing.
  assign tick = ms_cnt_ff == 16'(MS_CYCLES - 1);

  always_ff @(posedge core_clk) begin
    if (!rstn || tick) begin
      ms_cnt_ff <= 16'h0;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 16'h1;
    end
  end

  // Heartbeat producer; a zero period turns it off.
  always_ff @(posedge core_clk) begin
    if (!rstn || comm_rst || st_ff == CNM_INIT || hb_ms_ff == 16'h0) begin
      hb_cnt_ff  <= 16'h0;
      hb_pend_ff <= 1'b0;
    end else begin
      if (tick) begin
        hb_cnt_ff <= (hb_cnt_ff + 16'h1 >= hb_ms_ff) ? 16'h0 : hb_cnt_ff + 16'h1;
      end
      hb_pend_ff <= (tick && hb_cnt_ff + 16'h1 >= hb_ms_ff) | (hb_pend_ff & ~lch_hb); // [RULE12]
    end
  end

  // Boot-up message queued as the node leaves initialisation.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      boot_pend_ff <= 1'b0;
    end else begin
      boot_pend_ff <= (st_ff == CNM_INIT) | (boot_pend_ff & ~lch_boot & ~comm_rst); // [RULE18]
    end
  end

  // Guarding: reply queue, toggle and life-time supervision.
  always_ff @(posedge core_clk) begin
    if (!rstn || comm_rst) begin
      guard_pend_ff <= 1'b0;
      toggle_ff     <= 1'b0;
      guard_on_ff   <= 1'b0;
      life_cnt_ff   <= 24'h0;
      alarm_ff      <= 1'b0;
    end else begin
      guard_pend_ff <= guard_req | (guard_pend_ff & ~lch_guard);
      if (lch_guard) begin
        toggle_ff <= ~toggle_ff; // [RULE15]
      end
      if (guard_req) begin
        guard_on_ff <= 1'b1;
        life_cnt_ff <= 24'h0;
      end else if (tick && life_cnt_ff != 24'hffffff) begin
        life_cnt_ff <= life_cnt_ff + 24'h1;
      end
      alarm_ff <= (guard_on_ff & life_lim != 24'h0 & life_cnt_ff >= life_lim & ~guard_req)
                | (alarm_ff & ~guard_req); // [RULE17]
    end
  end

  // Transmit PDO triggers; everything is dropped outside operational.
  always_ff @(posedge core_clk) begin
    if (!rstn || comm_rst || !is_op) begin
      pend_ff  <= 4'h0;
      armed_ff <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        cyc_ff[i] <= 8'h00;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        logic arm;
        logic set;
        arm = tpdo_evt[i] | (rx_valid & rx_rtr
              & rx_id == cob(`CNM_FC_TPDO1 + {1'b0, 2'(i), 8'h00}, node_ff)); // [RULE4]
        set = 1'b0;
        if (tt_ff[i] == `CNM_TT_ACYC) begin
          armed_ff[i] <= (arm | armed_ff[i]) & ~sync_hit;
          set = sync_hit & (arm | armed_ff[i]); // [RULE8]
        end else if (tt_ff[i] <= `CNM_TT_CYCMAX) begin
          if (sync_hit) begin
            set = cyc_ff[i] + 8'h01 >= tt_ff[i]; // [RULE9]
            cyc_ff[i] <= set ? 8'h00 : cyc_ff[i] + 8'h01;
          end
        end else if (tt_ff[i] >= `CNM_TT_ASYNC) begin
          set = arm | (apb_wr & a_tdat & a_idx == 2'(i)); // [RULE10]
        end
        pend_ff[i] <= set | (pend_ff[i] & ~lch_pdo[i]); // [RULE6]
      end
    end
  end

  // Inhibit counters hold off a PDO for at least the set number of ms.
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rstn) begin
        inh_cnt_ff[i] <= 17'h0;
      end else if (lch_pdo[i]) begin
        inh_cnt_ff[i] <= {1'b0, inh_ff[i]} + {16'h0, inh_ff[i] != 16'h0}; // [RULE11]
      end else if (tick && inh_cnt_ff[i] != 17'h0) begin
        inh_cnt_ff[i] <= inh_cnt_ff[i] - 17'h1;
      end
    end
  end

  // Launch choice: PDOs first since their identifiers are lower.
  always_comb begin
    lch_pdo   = 4'h0;
    lch_guard = 1'b0;
    lch_hb    = 1'b0;
    lch_boot  = 1'b0;
    lch_idx   = 2'b00;
    if (tx_st_ff == CNM_TX_IDLE) begin
      for (int i = 3; i >= 0; i--) begin
        if (pend_ff[i] && inh_cnt_ff[i] == 17'h0 && is_op) begin
          lch_idx = 2'(i); // [RULE22]
        end
      end
      if (pend_ff[lch_idx] && inh_cnt_ff[lch_idx] == 17'h0 && is_op) begin
        lch_pdo[lch_idx] = 1'b1;
      end else if (boot_pend_ff) begin
        lch_boot = 1'b1;
      end else if (guard_pend_ff) begin
        lch_guard = 1'b1;
      end else if (hb_pend_ff) begin
        lch_hb = 1'b1;
      end
    end
  end

  cnm_pdo_mem u_mem (
    .core_clk (core_clk),
    .rstn     (rstn),
    .we       ({apb_wr & a_tdat & paddr[2], apb_wr & a_tdat & ~paddr[2]}),
    .waddr    (a_idx),
    .wdata    (pwdata),
    .raddr    (lch_idx),
    .rdata_ff (mem_rdata)
  );

  // Transmit sequencer; a PDO waits one cycle for its payload.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_st_ff    <= CNM_TX_IDLE;
      tx_valid_ff <= 1'b0;
      tx_id_ff    <= 11'h0;
      tx_dlc_ff   <= 4'h0;
      tx_data_ff  <= 64'h0;
    end else begin
      case (tx_st_ff)
        CNM_TX_IDLE: begin
          tx_dlc_ff <= `CNM_DLC_BYTE;
          tx_id_ff  <= cob(`CNM_FC_ERRCTL, node_ff); // [RULE12]
          if (lch_pdo != 4'h0) begin
            tx_id_ff <= cob(`CNM_FC_TPDO1 + {1'b0, lch_idx, 8'h00}, node_ff); // [RULE4]
            tx_st_ff <= CNM_TX_READ;
          end else if (lch_boot) begin
            tx_data_ff  <= {57'h0, `CNM_ST_BOOT}; // [RULE18]
            tx_valid_ff <= 1'b1;
            tx_st_ff    <= CNM_TX_SEND;
          end else if (lch_guard || lch_hb) begin
            tx_data_ff  <= {56'h0, lch_guard & toggle_ff, st_code(st_ff)}; // [RULE15] [RULE16]
            tx_valid_ff <= 1'b1;
            tx_st_ff    <= CNM_TX_SEND;
          end
        end
        CNM_TX_READ: begin
          tx_data_ff  <= mem_rdata;
          tx_dlc_ff   <= `CNM_DLC_PDO;
          tx_valid_ff <= 1'b1;
          tx_st_ff    <= CNM_TX_SEND;
        end
        CNM_TX_SEND: begin
          if (tx_ready) begin
            tx_valid_ff <= 1'b0;
            tx_st_ff    <= CNM_TX_IDLE;
          end
        end
        default: tx_st_ff <= CNM_TX_IDLE;
      endcase
    end
  end

  // Receive PDOs, passed on only while operational.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rpdo_valid_ff <= 1'b0;
      rpdo_idx_ff   <= 2'b00;
      rpdo_dlc_ff   <= 4'h0;
      rpdo_data_ff  <= 64'h0;
    end else begin
      rpdo_valid_ff <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        if (rx_valid && !rx_rtr && is_op
            && rx_id == cob(`CNM_FC_RPDO1 + {1'b0, 2'(i), 8'h00}, node_ff)) begin
          rpdo_valid_ff <= 1'b1; // [RULE5] [RULE22]
          rpdo_idx_ff   <= 2'(i);
          rpdo_dlc_ff   <= rx_dlc;
          rpdo_data_ff  <= rx_data;
        end
      end
    end
  end

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign tx_valid    = tx_valid_ff;
  assign tx_id       = tx_id_ff;
  assign tx_dlc      = tx_dlc_ff;
  assign tx_data     = tx_data_ff;
  assign rpdo_valid  = rpdo_valid_ff;
  assign rpdo_idx    = rpdo_idx_ff;
  assign rpdo_dlc    = rpdo_dlc_ff;
  assign rpdo_data   = rpdo_data_ff;
  assign guard_alarm = alarm_ff;
  assign nmt_state   = st_code(st_ff);
endmodule : cnm_node

`default_nettype wire

/* tb/cnm_node_sva.sv */
// Port-level assertions for the node messaging block.
// Assumes one clock, sync active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none

module cnm_node_sva (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rstn,
  // Register bus.
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Frames.
  input wire logic        rx_valid,
  input wire logic [10:0] rx_id,
  input wire logic        rx_rtr,
  input wire logic [3:0]  rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic        tx_valid,
  input wire logic [10:0] tx_id,
  input wire logic [3:0]  tx_dlc,
  input wire logic [63:0] tx_data,
  input wire logic        tx_ready,
  // Application side.
  input wire logic        rpdo_valid,
  input wire logic [6:0]  nmt_state
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  boot_seq_a: assert property (
    $rose(rstn) |=> nmt_state == 7'h7f ##1 (tx_valid && tx_id == 11'h701 && tx_dlc == 4'h1))
    else $error("boot-up wrong");
  nmt_cmd_a: assert property (
    rx_valid && rx_id == 11'h000 && !rx_rtr && rx_dlc >= 4'h2 && rx_data[15:8] == 8'h00
    && rx_data[7:0] inside {8'h01, 8'h02, 8'h80} && nmt_state != 7'h00
    |=> nmt_state == ($past(rx_data[7:0]) == 8'h01 ? 7'h05 :
                      $past(rx_data[7:0]) == 8'h02 ? 7'h04 : 7'h7f))
    else $error("bad state after command");
  rpdo_op_a: assert property (rpdo_valid |-> $past(nmt_state) == 7'h05)
    else $error("rpdo outside op");
  pdo_frame_a: assert property (
    tx_valid && tx_id[10:7] inside {4'h3, 4'h5, 4'h7, 4'h9}
    |-> tx_dlc == 4'h8 && tx_id[6:0] != 7'h00)
    else $error("tpdo frame bad");
  errctl_fmt_a: assert property (
    tx_valid && tx_id[10:7] == 4'he |-> tx_dlc == 4'h1 && tx_data[63:8] == 56'h0
    && tx_data[6:0] inside {7'h00, 7'h04, 7'h05, 7'h7f})
    else $error("error control frame bad");
  no_reply_a: assert property (tx_valid |-> tx_id[10:7] != 4'h0)
    else $error("management id sent");
  tx_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_dlc) && $stable(tx_data))
    else $error("frame changed early");
  apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb wait wrong");
  apb_err_a: assert property (pready && (paddr >= 8'h40 || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("bad address taken");

  cover property ($rose(tx_valid) && tx_id[10:7] == 4'he && tx_data[7]);
  cover property (tx_valid && tx_ready && tx_id[10:7] == 4'h9);
  cover property (rpdo_valid);
endmodule : cnm_node_sva

bind cnm_node cnm_node_sva u_sva (.*);

`default_nettype wire

/* tb/cnm_can_model.sv */
// Frame-level model of the bus master and its CAN controller.
// Assumes the node on one clock; the bench calls send_frame.
`timescale 1ns/1ps
`default_nettype none

module cnm_can_model #(
  parameter int HB_LIMIT = 100
) (
  // Clock.
  input  wire logic        core_clk,
  // Frames to the node.
  output var  logic        rx_valid,
  output var  logic [10:0] rx_id,
  output var  logic        rx_rtr,
  output var  logic [3:0]  rx_dlc,
  output var  logic [63:0] rx_data,
  // Frames from the node.
  input  wire logic        tx_valid,
  input  wire logic [10:0] tx_id,
  input  wire logic [3:0]  tx_dlc,
  input  wire logic [63:0] tx_data,
  output var  logic        tx_ready,
  // Stall control.
  input  wire logic        slow
);
  logic [78:0] got_q[$];
  logic        ph_ff = 1'b0;
  int          hb_gap = 0;
  logic        hb_late;

  initial begin
    {rx_valid, rx_id, rx_rtr, rx_dlc, rx_data, tx_ready} = '0;
  end

  // A slow controller takes frames only every other cycle.
  always @(posedge core_clk) begin
    ph_ff    <= ~ph_ff;
    tx_ready <= ~slow | ph_ff;
    if (tx_valid && tx_ready) begin
      got_q.push_back({tx_id, tx_dlc, tx_data});
    end
  end

  // Overdue error control traffic raises the alarm.
  always @(posedge core_clk) begin
    hb_gap <= (tx_valid && tx_ready && tx_id[10:7] == 4'he) ? 0 : hb_gap + 1;
  end
  assign hb_late = hb_gap > HB_LIMIT;

  // Only this master sends commands, sync and guard requests.
  task automatic send_frame(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
                            input logic [63:0] d);
    @(posedge core_clk);
    {rx_valid, rx_id, rx_rtr, rx_dlc, rx_data} <= {1'b1, id, rtr, dlc, d};
    @(posedge core_clk);
    // Idle id and data lines show the inverse so a stale frame is never reused.
    {rx_valid, rx_id, rx_data} <= {1'b0, ~id, ~d};
  endtask : send_frame
endmodule : cnm_can_model

`default_nettype wire

/* tb/test_canopen_node_messaging.sv */
// Self-checking bench for the node messaging block.
// Assumes the frame model and a millisecond of MS cycles.
`timescale 1ns/1ps
`default_nettype none

module test_canopen_node_messaging;
  localparam int          MS = 20;
  localparam logic [7:0]  ND = 8'h05;
  // Rows: wr, addr, wdata, exp rdata, exp error.
  localparam logic [73:0] ROWS [20] = '{
    {1'b0, 8'h00, 32'h0, 32'h1, 1'b0}, {1'b0, 8'h04, 32'h0, 32'h7f, 1'b0},
    {1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h10, 32'h0, 32'hff, 1'b0},
    {1'b0, 8'h40, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h06, 32'h5, 32'h0, 1'b1},
    {1'b1, 8'h00, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h00, 32'h0, 32'h1, 1'b0},
    {1'b1, 8'h00, 32'h5, 32'h0, 1'b0}, {1'b1, 8'h04, 32'h0, 32'h0, 1'b0},
    {1'b0, 8'h04, 32'h0, 32'h7f, 1'b0}, {1'b1, 8'h10, 32'h1, 32'h0, 1'b0},
    {1'b1, 8'h14, 32'h2, 32'h0, 1'b0}, {1'b1, 8'h18, 32'h000200fe, 32'h0, 1'b0},
    {1'b1, 8'h1c, 32'h0, 32'h0, 1'b0}, {1'b0, 8'h18, 32'h0, 32'h000200fe, 1'b0},
    {1'b1, 8'h20, 32'h44332211, 32'h0, 1'b0}, {1'b1, 8'h24, 32'h88776655, 32'h0, 1'b0},
    {1'b1, 8'h38, 32'hcafe0001, 32'h0, 1'b0}, {1'b0, 8'h20, 32'h0, 32'h0, 1'b0}};
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, erv, slow;
  logic        rx_valid, rx_rtr, tx_valid, tx_ready, rpdo_valid, guard_alarm;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [10:0] rx_id, tx_id;
  logic [3:0]  rx_dlc, tx_dlc, tpdo_evt, rpdo_dlc;
  logic [63:0] rx_data, tx_data, rpdo_data;
  logic [1:0]  rpdo_idx;
  logic [6:0]  nmt_state;
  int          checks = 0, n_errors = 0, cyc = 0, n_rpdo = 0, t0;

  cnm_node #(.MS_CYCLES(MS)) DUT (.*);
  cnm_can_model u_can (.*);

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rpdo_valid === 1'b1) begin
      n_rpdo <= n_rpdo + 1;
    end
  end

  task automatic chk(input string nm, input logic [78:0] exp, input logic [78:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) begin
      n_errors++;
    end
    {rdv, erv} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask : apb

  task automatic expf(input logic [10:0] id, input logic [3:0] dl, input logic [63:0] d);
    repeat (400) begin
      if (u_can.got_q.size() == 0) begin
        @(posedge core_clk);
      end
    end
    chk("frame", {id, dl, d}, u_can.got_q.size() ? u_can.got_q.pop_front() : 79'h0);
  endtask : expf

  task automatic nmt(input logic [7:0] cs, input logic [7:0] nd, input logic [6:0] st);
    u_can.send_frame(11'h000, 1'b0, 4'h2, {48'h0, nd, cs});
    repeat (4) @(posedge core_clk);
    chk("state", st, nmt_state);
  endtask : nmt

  // Sync no faster than 1 kHz.
  task automatic sync();
    u_can.send_frame(11'h080, 1'b0, 4'h0, 64'h0);
    repeat (MS) @(posedge core_clk);
  endtask : sync

  task automatic guard();
    u_can.send_frame(11'h705, 1'b1, 4'h0, 64'h0);
  endtask : guard

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, tpdo_evt, slow} = '0;
    repeat (12) @(posedge core_clk);
    chk("reset state", 79'h0, nmt_state);
    rstn <= 1'b1;
    expf(11'h701, 4'h1, 64'h0);
    foreach (ROWS[i]) begin
      apb(ROWS[i][73], ROWS[i][72:65], ROWS[i][64:33]);
      chk("read data", ROWS[i][32:1], rdv);
      chk("slave error", ROWS[i][0], erv);
    end
    nmt(8'h01, 8'h06, 7'h7f);
    nmt(8'h01, 8'h00, 7'h05);
    nmt(8'h80, 8'h00, 7'h7f);
    nmt(8'h01, ND, 7'h05);
    sync();
    expf(11'h185, 4'h8, 64'h8877665544332211);
    tpdo_evt <= 4'h8;
    @(posedge core_clk);
    tpdo_evt <= 4'h0;
    slow <= 1'b1;
    sync();
    expf(11'h185, 4'h8, 64'h8877665544332211);
    expf(11'h285, 4'h8, 64'h0);
    expf(11'h485, 4'h8, 64'hcafe0001);
    sync();
    expf(11'h185, 4'h8, 64'h8877665544332211);
    slow <= 1'b0;
    chk("no more frames", 79'h0, u_can.got_q.size());
    apb(1'b1, 8'h30, 32'h1);
    expf(11'h385, 4'h8, 64'h1);
    t0 = cyc;
    apb(1'b1, 8'h30, 32'h2);
    expf(11'h385, 4'h8, 64'h2);
    chk("inhibit spacing", 79'h1, (cyc - t0) >= 2 * MS);
    nmt(8'h02, 8'h00, 7'h04);
    sync();
    u_can.send_frame(11'h205, 1'b0, 4'h8, 64'h1234);
    repeat (4) @(posedge core_clk);
    chk("quiet when stopped", 79'h0, u_can.got_q.size() + n_rpdo);
    nmt(8'h01, ND, 7'h05);
    u_can.send_frame(11'h505, 1'b0, 4'h8, 64'h0123456789abcdef);
    repeat (3) @(posedge core_clk);
    chk("receive count", 79'h1, n_rpdo);
    chk("receive object", {2'h3, 4'h8, 64'h0123456789abcdef},
        {rpdo_idx, rpdo_dlc, rpdo_data});
    apb(1'b1, 8'h0c, 32'h00020001);
    guard();
    expf(11'h705, 4'h1, 64'h05);
    chk("alarm idle", 79'h0, guard_alarm);
    repeat (4 * MS) @(posedge core_clk);
    chk("alarm raised", 79'h1, guard_alarm);
    guard();
    expf(11'h705, 4'h1, 64'h85);
    chk("alarm cleared", 79'h0, guard_alarm);
    nmt(8'h82, ND, 7'h7f);
    expf(11'h705, 4'h1, 64'h0);
    guard();
    expf(11'h705, 4'h1, 64'h7f);
    nmt(8'h81, 8'h00, 7'h7f);
    expf(11'h705, 4'h1, 64'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("config restored", 79'hff, rdv);
    apb(1'b1, 8'h08, 32'h1);
    expf(11'h705, 4'h1, 64'h7f);
    expf(11'h705, 4'h1, 64'h7f);
    chk("heartbeat late", 79'h0, u_can.hb_late);
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    u_can.got_q.delete();
    rstn <= 1'b1;
    expf(11'h701, 4'h1, 64'h0);
    results();
  end

  // Catches a hang; the run needs a few hundred cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    results();
  end
endmodule : test_canopen_node_messaging

`default_nettype wire
